// ### src/serial_control_pkg.sv
package serial_control_pkg;

    // ------------------------------------------------------------------
    // Register indices.
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_MODE_CONTROL = 4'h0;
    localparam logic [3:0] REG_DEVICE_STATUS = 4'h1;
    localparam logic [3:0] REG_TONE_ENHANCER = 4'h2;
    localparam logic [3:0] REG_CLOCK_SETTING = 4'h3;
    localparam logic [3:0] REG_DECODE_SECONDS = 4'h4;
    localparam logic [3:0] REG_AUDIO_FORMAT_INFO = 4'h5;
    localparam logic [3:0] REG_RAM_DATA_WINDOW = 4'h6;
    localparam logic [3:0] REG_RAM_POINTER = 4'h7;
    localparam logic [3:0] REG_HEADER_WORD_LOW = 4'h8;
    localparam logic [3:0] REG_HEADER_WORD_HIGH = 4'h9;
    localparam logic [3:0] REG_APP_ENTRY_ADDRESS = 4'hA;
    localparam logic [3:0] REG_OUTPUT_VOLUME = 4'hB;
    localparam logic [3:0] REG_APP_CONTROL_0 = 4'hC;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [15:0] MODE_RESET = 16'h0800;
    localparam logic [15:0] STATUS_RESET = 16'h003C;
    localparam logic [15:0] STATUS_BOOT = 16'h0038;
    localparam logic [15:0] STATUS_READY = 16'h0030;
    localparam logic [15:0] MODE_WRITE_MASK = 16'h7FFF;

    // ------------------------------------------------------------------
    // Mode control bit positions.
    // ------------------------------------------------------------------
    localparam int BIT_LEFT_INVERT = 0;
    localparam int BIT_SOFT_RESET = 2;
    localparam int BIT_EARLY_EXIT = 3;
    localparam int BIT_SOFT_POWERDOWN = 4;
    localparam int BIT_TEST_ENABLE = 5;
    localparam int BIT_STREAM_MODE = 6;
    localparam int BIT_EXTENSION_DECODE = 7;
    localparam int BIT_SAMPLE_EDGE_SELECT = 8;
    localparam int BIT_BIT_ORDER_REVERSE = 9;
    localparam int BIT_SHARED_SELECT = 10;
    localparam int BIT_NATIVE_SERIAL_MODES = 11;
    localparam int BIT_RECORD_ENABLE = 12;
    localparam int BIT_RECORD_HIGHPASS = 13;
    localparam int BIT_RECORD_SOURCE_SELECT = 14;

    // ------------------------------------------------------------------
    // Control port instructions.
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;

    // ------------------------------------------------------------------
    // Busy times after a write, in internal clock cycles.
    // ------------------------------------------------------------------
    localparam int BUSY_W = 15;
    localparam int BUSY_MODE_CLK = 70;
    localparam int BUSY_STATUS_CLK = 40;
    localparam int BUSY_TONE_CLK = 2100;
    localparam int BUSY_SECONDS_CLK = 40;
    localparam int BUSY_AUDIO_CLK = 3200;
    localparam int BUSY_RAM_CLK = 80;
    localparam int BUSY_APP_ENTRY_CLK = 3200;
    localparam int BUSY_VOLUME_CLK = 2100;
    localparam int BUSY_APP_CTRL_CLK = 50;
    localparam int BUSY_CLOCK_XTAL = 11000;
    localparam int BUSY_SOFT_RESET_XTAL = 16600;

    // ------------------------------------------------------------------
    // Status settle time.
    // ------------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int STATUS_SETTLE_MS = 100;
    localparam int STATUS_SETTLE_CYCLES = STATUS_SETTLE_MS * CLK_KHZ;

endpackage

// ### src/serial_control_register_bank.sv
`timescale 1ns/1ps

module serial_control_register_bank
    import serial_control_pkg::*;
#(
    parameter int CLOCK_BUSY_CYCLES = BUSY_CLOCK_XTAL,
    parameter int RESET_BUSY_CYCLES = BUSY_SOFT_RESET_XTAL,
    parameter int SETTLE_CYCLES = STATUS_SETTLE_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Control port pins.
    input wire logic i_select_n,
    input wire logic i_sclk,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    // Data request pin and its sources.
    input wire logic i_buffer_ready,
    input wire logic i_app_running,
    output logic o_data_request,
    // Decoder status inputs.
    input wire logic i_header_valid,
    input wire logic [15:0] i_header_low,
    input wire logic [15:0] i_header_high,
    input wire logic i_early_exit_done,
    // Mode controls toward the decoder and data port.
    output logic o_left_invert,
    output logic o_soft_reset_pulse,
    output logic o_early_exit,
    output logic o_soft_powerdown,
    output logic o_test_enable,
    output logic o_stream_mode,
    output logic o_extension_decode,
    output logic o_sample_falling_edge,
    output logic o_lsb_first,
    output logic o_shared_select,
    output logic o_record_start_pulse,
    output logic o_record_highpass,
    output logic o_record_line_input,
    // Register contents used elsewhere.
    output logic [15:0] o_tone_enhancer,
    output logic [15:0] o_clock_setting,
    output logic [15:0] o_output_volume,
    output logic [15:0] o_app_entry_address
);

    // ------------------------------------------------------------------
    // Types and state.
    // ------------------------------------------------------------------
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CMD = 5'b00010,
        ST_ADDR = 5'b00100,
        ST_DATA = 5'b01000,
        ST_HOLD = 5'b10000
    } spi_state_type;

    typedef struct packed {
        spi_state_type state;
        logic [3:0] cnt;
        logic sclk_m;
        logic sclk_s;
        logic sclk_d;
        logic sel_m;
        logic sel_s;
        logic si_m;
        logic si_s;
        logic [7:0] opcode;
        logic [7:0] addr;
        logic [15:0] shift;
        logic [15:0] out_shift;
        logic so;
        logic so_oe;
        logic [15:0][15:0] regs;
        logic [BUSY_W-1:0] busy;
        logic status_boot;
        logic status_settling;
        logic [SETTLE_W-1:0] settle_cnt;
        logic reset_pulse;
        logic record_pulse;
    } bank_state_type;

    bank_state_type state_reg;
    bank_state_type state_next;
    logic wr_commit;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;

    // Busy time for a write to one index.
    function automatic logic [BUSY_W-1:0] busy_time(
        input logic [3:0] idx,
        input logic [15:0] data
    );
        logic [BUSY_W-1:0] t;
        t = BUSY_W'(BUSY_APP_CTRL_CLK);
        case (idx)
            REG_MODE_CONTROL: begin
                if (data[BIT_SOFT_RESET]) begin
                    t = BUSY_W'(RESET_BUSY_CYCLES);
                end else begin
                    t = BUSY_W'(BUSY_MODE_CLK);
                end
            end
            REG_DEVICE_STATUS: t = BUSY_W'(BUSY_STATUS_CLK);
            REG_TONE_ENHANCER: t = BUSY_W'(BUSY_TONE_CLK);
            REG_CLOCK_SETTING: t = BUSY_W'(CLOCK_BUSY_CYCLES);
            REG_DECODE_SECONDS: t = BUSY_W'(BUSY_SECONDS_CLK);
            REG_AUDIO_FORMAT_INFO: t = BUSY_W'(BUSY_AUDIO_CLK);
            REG_RAM_DATA_WINDOW: t = BUSY_W'(BUSY_RAM_CLK);
            REG_RAM_POINTER: t = BUSY_W'(BUSY_RAM_CLK);
            REG_APP_ENTRY_ADDRESS: t = BUSY_W'(BUSY_APP_ENTRY_CLK);
            REG_OUTPUT_VOLUME: t = BUSY_W'(BUSY_VOLUME_CLK);
            default: t = BUSY_W'(BUSY_APP_CTRL_CLK);
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    // Synchronises the pins, runs the serial frame and updates registers.
    always_comb begin
        logic rise;
        logic fall;
        logic [15:0] word;
        state_next = state_reg;
        wr_commit = 1'b0;
        wr_addr = state_reg.addr;
        wr_data = 16'h0000;
        word = {state_reg.shift[14:0], state_reg.si_s};
        rise = state_reg.sclk_s & ~state_reg.sclk_d;
        fall = ~state_reg.sclk_s & state_reg.sclk_d;
        state_next.sclk_m = i_sclk;
        state_next.sclk_s = state_reg.sclk_m;
        state_next.sclk_d = state_reg.sclk_s;
        state_next.sel_m = i_select_n;
        state_next.sel_s = state_reg.sel_m;
        state_next.si_m = i_si;
        state_next.si_s = state_reg.si_m;
        state_next.reset_pulse = 1'b0;
        state_next.record_pulse = 1'b0;

        // Busy countdown; the soft reset bit drops as the wait ends.
        if (state_reg.busy != '0) begin
            state_next.busy = state_reg.busy - BUSY_W'(1);
            if (state_reg.busy == BUSY_W'(1)) begin
                state_next.regs[REG_MODE_CONTROL][BIT_SOFT_RESET] = 1'b0;
            end
        end

        // Status leaves its reset value at once, then settles later.
        if (state_reg.status_boot) begin
            state_next.status_boot = 1'b0;
            state_next.regs[REG_DEVICE_STATUS] = STATUS_BOOT;
        end else if (state_reg.status_settling) begin
            if (state_reg.settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                state_next.status_settling = 1'b0;
                state_next.regs[REG_DEVICE_STATUS] = STATUS_READY;
            end else begin
                state_next.settle_cnt = state_reg.settle_cnt + SETTLE_W'(1);
            end
        end

        // Header words come from the decoder, or are cleared by soft reset; early exit clears only the high word.
        if (i_header_valid) begin
            state_next.regs[REG_HEADER_WORD_LOW] = i_header_low;
            state_next.regs[REG_HEADER_WORD_HIGH] = i_header_high;
        end

        // Early exit finished: drop the request and the high header word.
        if (i_early_exit_done &&
                state_reg.regs[REG_MODE_CONTROL][BIT_EARLY_EXIT]) begin
            state_next.regs[REG_MODE_CONTROL][BIT_EARLY_EXIT] = 1'b0;
            state_next.regs[REG_HEADER_WORD_HIGH] = 16'h0000;
        end

        // Serial frame: instruction, index, then sixteen data bits.
        if (state_reg.sel_s) begin
            state_next.state = ST_IDLE;
            state_next.cnt = 4'h0;
            state_next.so_oe = 1'b0;
            state_next.so = 1'b0;
        end else begin
            case (state_reg.state)
                ST_IDLE: begin
                    state_next.state = ST_CMD;
                    state_next.cnt = 4'h0;
                end
                ST_CMD: begin
                    if (rise) begin
                        state_next.shift = word;
                        state_next.cnt = state_reg.cnt + 4'h1;
                        if (state_reg.cnt == 4'h7) begin
                            state_next.opcode = word[7:0];
                            state_next.state = ST_ADDR;
                            state_next.cnt = 4'h0;
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        state_next.shift = word;
                        state_next.cnt = state_reg.cnt + 4'h1;
                        if (state_reg.cnt == 4'h7) begin
                            state_next.addr = word[7:0];
                            state_next.state = ST_DATA;
                            state_next.cnt = 4'h0;
                            state_next.so_oe = (state_reg.opcode == OP_READ);
                            state_next.out_shift = 16'h0000;
                            if (word[7:4] == 4'h0) begin
                                state_next.out_shift =
                                    state_reg.regs[word[3:0]];
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (fall && state_reg.so_oe) begin
                        state_next.so = state_reg.out_shift[15];
                        state_next.out_shift =
                            {state_reg.out_shift[14:0], 1'b0};
                    end
                    if (rise) begin
                        state_next.shift = word;
                        state_next.cnt = state_reg.cnt + 4'h1;
                        if (state_reg.cnt == 4'hF) begin
                            state_next.state = ST_HOLD;
                            wr_commit = (state_reg.opcode == OP_WRITE);
                            wr_data = word;
                        end
                    end
                end
                ST_HOLD: begin
                    // Extra clocks are ignored until select rises.
                    state_next.so_oe = 1'b0;
                end
                default: begin
                    state_next.state = ST_IDLE;
                end
            endcase
        end

        // Register write: header words and out-of-range indices ignored.
        if (wr_commit && wr_addr[7:4] == 4'h0 &&
                wr_addr[3:0] != REG_HEADER_WORD_LOW &&
                wr_addr[3:0] != REG_HEADER_WORD_HIGH) begin
            state_next.busy = busy_time(wr_addr[3:0], wr_data);
            if (wr_addr[3:0] == REG_MODE_CONTROL) begin
                state_next.regs[REG_MODE_CONTROL] =
                    wr_data & MODE_WRITE_MASK;
                if (wr_data[BIT_SOFT_RESET]) begin
                    state_next.reset_pulse = 1'b1;
                    state_next.regs[REG_DECODE_SECONDS] = 16'h0000;
                    state_next.regs[REG_HEADER_WORD_LOW] = 16'h0000;
                    state_next.regs[REG_HEADER_WORD_HIGH] = 16'h0000;
                    state_next.record_pulse =
                        wr_data[BIT_RECORD_ENABLE];
                end
            end else begin
                state_next.regs[wr_addr[3:0]] = wr_data;
                if (wr_addr[3:0] == REG_DEVICE_STATUS) begin
                    state_next.status_settling = 1'b0;
                    state_next.status_boot = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    // Synchronous reset loads constants only.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '0;
            state_reg.state <= ST_IDLE;
            state_reg.sel_m <= 1'b1;
            state_reg.sel_s <= 1'b1;
            state_reg.regs[REG_MODE_CONTROL] <= MODE_RESET;
            state_reg.regs[REG_DEVICE_STATUS] <= STATUS_RESET;
            state_reg.status_boot <= 1'b1;
            state_reg.status_settling <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    // Data request is low while busy, while an app routine runs, or while
    // it was already held low by the buffer.
    assign o_data_request = (state_reg.busy == '0) & i_buffer_ready &
                            ~i_app_running;
    assign o_so = state_reg.so;
    assign o_so_oe = state_reg.so_oe;
    assign o_soft_reset_pulse = state_reg.reset_pulse;
    assign o_record_start_pulse = state_reg.record_pulse;

    // Mode controls come straight from the mode register; shared select also needs the native serial modes bit.
    assign o_left_invert =
        state_reg.regs[REG_MODE_CONTROL][BIT_LEFT_INVERT];
    assign o_early_exit = state_reg.regs[REG_MODE_CONTROL][BIT_EARLY_EXIT];
    assign o_soft_powerdown =
        state_reg.regs[REG_MODE_CONTROL][BIT_SOFT_POWERDOWN];
    assign o_test_enable =
        state_reg.regs[REG_MODE_CONTROL][BIT_TEST_ENABLE];
    assign o_stream_mode =
        state_reg.regs[REG_MODE_CONTROL][BIT_STREAM_MODE];
    assign o_extension_decode =
        state_reg.regs[REG_MODE_CONTROL][BIT_EXTENSION_DECODE];
    assign o_sample_falling_edge =
        state_reg.regs[REG_MODE_CONTROL][BIT_SAMPLE_EDGE_SELECT];
    assign o_lsb_first =
        state_reg.regs[REG_MODE_CONTROL][BIT_BIT_ORDER_REVERSE];
    assign o_shared_select =
        state_reg.regs[REG_MODE_CONTROL][BIT_SHARED_SELECT] &
        state_reg.regs[REG_MODE_CONTROL][BIT_NATIVE_SERIAL_MODES];
    assign o_record_highpass =
        state_reg.regs[REG_MODE_CONTROL][BIT_RECORD_HIGHPASS];
    assign o_record_line_input =
        state_reg.regs[REG_MODE_CONTROL][BIT_RECORD_SOURCE_SELECT];
    assign o_tone_enhancer = state_reg.regs[REG_TONE_ENHANCER];
    assign o_clock_setting = state_reg.regs[REG_CLOCK_SETTING];
    assign o_output_volume = state_reg.regs[REG_OUTPUT_VOLUME];
    assign o_app_entry_address = state_reg.regs[REG_APP_ENTRY_ADDRESS];

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // A mode write as it is committed.
    sequence seq_mode_write;
        wr_commit && wr_addr == 8'h00;
    endsequence

    // A mode write that asks for soft reset.
    sequence seq_reset_write;
        seq_mode_write and wr_data[BIT_SOFT_RESET];
    endsequence

    a_header_read_only: assert property (
        wr_commit && wr_addr == 8'h08 && !i_header_valid
        |=> $stable(state_reg.regs[REG_HEADER_WORD_LOW]))
        else $error("Header word changed by a write.");
    a_mode_busy_time: assert property (
        seq_mode_write and !wr_data[BIT_SOFT_RESET]
        |=> state_reg.busy == BUSY_W'(BUSY_MODE_CLK) && !o_data_request)
        else $error("Mode write busy time wrong.");
    a_request_held: assert property (
        o_data_request |-> state_reg.busy == '0 && i_buffer_ready)
        else $error("Data request high while held.");
    a_app_hold: assert property (i_app_running |-> !o_data_request)
        else $error("Data request high during app routine.");
    a_status_boot: assert property (
        $fell(i_reset) |-> state_reg.regs[REG_DEVICE_STATUS] == STATUS_RESET
        ##1 state_reg.regs[REG_DEVICE_STATUS] == STATUS_BOOT)
        else $error("Status boot sequence wrong.");
    a_reset_busy_time: assert property (
        seq_reset_write |=> state_reg.busy == BUSY_W'(RESET_BUSY_CYCLES)
        && state_reg.reset_pulse ##1 !state_reg.reset_pulse)
        else $error("Soft reset busy time wrong.");
    a_left_invert: assert property (
        seq_mode_write |=> o_left_invert == $past(wr_data[BIT_LEFT_INVERT]))
        else $error("Left invert not updated.");
    a_reset_clear: assert property (
        state_reg.busy == BUSY_W'(1) && !wr_commit
        |=> !state_reg.regs[REG_MODE_CONTROL][BIT_SOFT_RESET])
        else $error("Soft reset bit not cleared.");
    a_early_exit: assert property (
        i_early_exit_done && o_early_exit && !wr_commit
        |=> !o_early_exit && state_reg.regs[REG_HEADER_WORD_HIGH] == 16'h0000)
        else $error("Early exit not cleared.");
    a_mode_reset: assert property (
        $fell(i_reset) |-> state_reg.regs[REG_MODE_CONTROL] == MODE_RESET)
        else $error("Mode reset value wrong.");
    a_bit15_zero: assert property (!state_reg.regs[REG_MODE_CONTROL][15])
        else $error("Mode bit 15 set.");

endmodule // serial_control_register_bank

// ### testbench/host_spi_model.sv
`timescale 1ns/1ps

// Host controller driving the control port as a mode 0 master.
module host_spi_model (
    // Clock.
    input wire logic i_clk,
    // Control port pins.
    input wire logic i_so,
    output logic o_select_n,
    output logic o_sclk,
    output logic o_si
);
    // Idle pins until the first frame.
    initial begin
        o_select_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
    end

    // One frame: opcode, index, then one word, most significant bit first.
    task automatic xfer(input logic [7:0] op, input logic [7:0] idx,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] sh;
        sh = {op, idx, wd};
        rd = 16'h0000;
        o_select_n = 1'b0;
        for (int b = 31; b >= 0; b--) begin
            o_si = sh[b];
            repeat (6) @(negedge i_clk);
            if (b < 16) rd[b] = i_so;
            o_sclk = 1'b1;
            repeat (6) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (6) @(negedge i_clk);
        o_select_n = 1'b1;
        o_si = ~o_si; // A released line must not keep a stale level.
        repeat (6) @(negedge i_clk);
    endtask
endmodule // host_spi_model

// ### testbench/test_serial_control_register_bank.sv
`timescale 1ns/1ps

module test_serial_control_register_bank;
    import serial_control_pkg::*;
    logic clk = 1'b0, rst = 1'b1, so, so_oe, data_request, sel_n, sclk, si;
    logic buf_rdy = 1'b1, app_run = 1'b0, hv = 1'b0, ex_done = 1'b0;
    logic [15:0] hlo = 16'h0000, hhi = 16'h0000, rd, d;
    logic [15:0] tone, clk_set, output_volume, app_entry;
    logic [15:0] exp_r [16];
    logic [10:0] m;
    logic [7:0] n_rst = 8'h00, n_rec = 8'h00;
    int error_cnt = 0, n_checks = 0, n, b;

    serial_control_register_bank #(.CLOCK_BUSY_CYCLES(20),
        .RESET_BUSY_CYCLES(30), .SETTLE_CYCLES(10)) i_dut (.i_clk(clk),
        .i_reset(rst), .i_select_n(sel_n), .i_sclk(sclk), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_buffer_ready(buf_rdy),
        .i_app_running(app_run), .o_data_request(data_request),
        .i_header_valid(hv), .i_header_low(hlo), .i_header_high(hhi),
        .i_early_exit_done(ex_done), .o_left_invert(m[10]),
        .o_soft_reset_pulse(), .o_early_exit(m[9]),
        .o_soft_powerdown(m[8]), .o_test_enable(m[7]),
        .o_stream_mode(m[6]), .o_extension_decode(m[5]),
        .o_sample_falling_edge(m[4]), .o_lsb_first(m[3]),
        .o_shared_select(m[2]), .o_record_start_pulse(),
        .o_record_highpass(m[1]), .o_record_line_input(m[0]),
        .o_tone_enhancer(tone), .o_clock_setting(clk_set),
        .o_output_volume(output_volume), .o_app_entry_address(app_entry));
    host_spi_model i_host (.i_clk(clk), .i_so(so), .o_select_n(sel_n),
        .o_sclk(sclk), .o_si(si));

    // Clock and one-cycle pulse counters.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (i_dut.o_soft_reset_pulse === 1'b1) n_rst <= n_rst + 8'h01;
        if (i_dut.o_record_start_pulse === 1'b1) n_rec <= n_rec + 8'h01;
    end

    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] i, input logic [15:0] v);
        i_host.xfer(OP_WRITE, {4'h0, i}, v, rd);
    endtask
    task automatic rdr(input logic [3:0] i);
        i_host.xfer(OP_READ, {4'h0, i}, 16'h0000, rd);
    endtask
    // Counts cycles until data request is back, bounded by lim.
    task automatic wait_data_request(input int lim);
        n = 0;
        while (data_request !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    function automatic int busy_of(input logic [3:0] i);
        case (i)
            4'h0: return 70;
            4'h1, 4'h4: return 40;
            4'h2, 4'hB: return 2100;
            4'h3: return 20;
            4'h5, 4'hA: return 3200;
            4'h6, 4'h7: return 80;
            4'h8, 4'h9: return 0;
            default: return 50;
        endcase
    endfunction

    // Hang guard.
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    // Main sequence.
    initial begin
        n = $urandom(32'h9EE5B41E);
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            d = (i == 0) ? MODE_RESET : (i == 1) ? STATUS_READY : 16'h0000;
            rdr(i[3:0]);
            chk("reset value", d, rd);
        end
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom());
            if (i == 0) d = d & 16'hFFF9;
            wr(i[3:0], d);
            b = busy_of(i[3:0]);
            wait_data_request(b + 50);
            chk("busy", 1, n <= b && n + 24 >= b);
            if (i == 0) chk("mode pins", {d[0], d[3], d[4], d[5], d[6], d[7],
                d[8], d[9], d[10] & d[11], d[13], d[14]}, m);
            if (i == 0) d = d & 16'h7FFF;
            if (i == 8 || i == 9) d = 16'h0000;
            rdr(i[3:0]);
            chk("readback", d, rd);
            exp_r[i] = d;
        end
        // Register contents driven toward the decoder, and an idle output.
        chk("tone out", exp_r[2], tone);
        chk("clock out", exp_r[3], clk_set);
        chk("volume out", exp_r[11], output_volume);
        chk("app entry out", exp_r[10], app_entry);
        chk("so enable idle", 16'h0000, so_oe);
        buf_rdy = 1'b0;
        wr(4'h4, 16'h1234);
        repeat (60) @(negedge clk);
        chk("data_request held", 16'h0000, data_request);
        buf_rdy = 1'b1;
        app_run = 1'b1;
        wr(4'hC, 16'h0001);
        repeat (100) @(negedge clk);
        chk("data_request app", 16'h0000, data_request);
        app_run = 1'b0;
        wait_data_request(5);
        chk("data_request free", 16'h0001, data_request);
        wr(4'h0, 16'h0840);
        wait_data_request(100);
        chk("stream pin", 16'h0001, m[6]);
        wr(4'h0, 16'h3004);
        wait_data_request(100);
        chk("reset busy", 1, n <= 30 && n + 24 >= 30);
        chk("pulses", 16'h0101, {n_rst, n_rec});
        rdr(4'h0);
        chk("mode after reset", 16'h3000, rd);
        hlo = 16'($urandom());
        hhi = 16'($urandom());
        hv = 1'b1;
        @(negedge clk);
        hv = 1'b0;
        rdr(4'h8);
        chk("header low", hlo, rd);
        wr(4'h0, 16'h0008);
        wait_data_request(100);
        chk("early exit pin", 1, m[9]);
        ex_done = 1'b1;
        @(negedge clk);
        ex_done = 1'b0;
        rdr(4'h0);
        chk("early exit bit", 16'h0000, rd);
        rdr(4'h9);
        chk("header high", 16'h0000, rd);
        final_report();
    end
endmodule // test_serial_control_register_bank
